// ===== gps_cfg.svh
`ifndef GPS_CFG_SVH
`define GPS_CFG_SVH
// ==========================================
// Register offsets
`define GPS_ADDR_W 4
`define GPS_OFS_P8_DIR 4'h0
`define GPS_OFS_P8_DATA 4'h1
`define GPS_OFS_PC_DIR 4'h2
`define GPS_OFS_PC_DATA 4'h3
`define GPS_OFS_PD_DIR 4'h4
`define GPS_OFS_PD_DATA 4'h5
`define GPS_OFS_TMR_ODIS 4'h6
`define GPS_OFS_TMR_FUNC 4'h7
`define GPS_OFS_TMR_PWM 4'h8
`define GPS_OFS_TMR_IOA0 4'h9
`define GPS_OFS_TMR_IOC0 4'hA
`define GPS_OFS_TMR_IOA1 4'hB
`define GPS_OFS_TMR_IOC1 4'hC
// ==========================================
// Field positions
`define GPS_FUNC_CMD_LSB 0
`define GPS_FUNC_PWM_SEL_BIT 2
`define GPS_FUNC_SYNC_BIT 3
`define GPS_P8_LSB 5
`define GPS_PWM_IMPL 8'hEE
// ==========================================
// Reset and fixed read values
`define GPS_RST_BYTE 8'h00
`define GPS_RST_P8 3'h0
`define GPS_RST_PC 4'h0
`define GPS_P8_RSVD_RD 5'h1F
`define GPS_PC_RSVD_RD 4'hF
`define GPS_RD_UNMAPPED 8'h00
`endif

// ===== gps_pkg.sv
package gps_pkg;
   typedef logic [7:0] gps_byte_t;
   typedef enum logic [2:0] {
      GPS_PIN_A0,
      GPS_PIN_B0,
      GPS_PIN_CD,
      GPS_PIN_A1,
      GPS_PIN_B1
   } gps_pin_kind_t;
endpackage

// ===== gps_pinmux.sv
`timescale 1ns/1ps
`default_nettype none
module gps_pinmux
   import gps_pkg::*;
#(
   parameter gps_pin_kind_t KIND = GPS_PIN_CD
) (
   input wire logic out_disable,
   input wire logic [1:0] comb_mode,
   input wire logic pwm_sel,
   input wire logic start_sync,
   input wire logic pwm_mode,
   input wire logic [3:0] io_code,
   output logic timer_owns,
   output logic force_input
);
   logic sel3;
   logic sel4;
   logic comb_on;

   // 3-bit code 01X or 001, 4-bit code 101X or 1001
   assign sel3 = (io_code[2] == 1'b0) && (io_code[2:0] != 3'b000);
   assign sel4 = (io_code[3:1] == 3'b101) || (io_code == 4'b1001);
   assign comb_on = (comb_mode != 2'b00);

   always_comb begin
      timer_owns = 1'b0;
      force_input = 1'b0;
      if (out_disable) begin
         timer_owns = 1'b0;
      end else begin
         case (KIND)
            GPS_PIN_CD: begin
               if (comb_on) timer_owns = 1'b1;
               else if (!pwm_sel) timer_owns = 1'b0;
               else if (pwm_mode) timer_owns = 1'b1;
               else timer_owns = sel4;
            end
            GPS_PIN_B1: begin
               if (comb_on) timer_owns = 1'b1;
               else if (!pwm_sel) timer_owns = 1'b0;
               else if (pwm_mode) timer_owns = 1'b1;
               else timer_owns = sel3;
            end
            GPS_PIN_A1: begin
               if (comb_on) timer_owns = 1'b1;
               else if (!pwm_sel) timer_owns = 1'b0;
               else timer_owns = sel3;
            end
            GPS_PIN_B0: begin
               // Only one narrow case leaves this pin to the port
               timer_owns = !(pwm_sel && !pwm_mode && !comb_on && !sel3);
            end
            GPS_PIN_A0: begin
               if (start_sync) timer_owns = 1'b0;
               else if (comb_on) force_input = 1'b1;
               else if (!pwm_sel) timer_owns = 1'b1;
               else timer_owns = sel3;
            end
            default: begin
               timer_owns = 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== gps_ports.sv
// Summary of operation
// - First port upper pins: direction bit 1 outputs
// - First port read: latch if output, pin if input
// - Reserved data bits always read as one
// - Second port low pins: direction bit 1 outputs
// - Second port read by direction, data reset zero
// - Shared port: eight direction bits, 1 outputs
// - Shared port read by direction, data reset zero
// - Timer output selection overrides port settings
// - Output disable gives plain port, pin feeds capture
// - Mode 00, PWM select 0: port pins except channel-0 A and B
// - C/D pins: 4-bit code picks timer output
// - PWM-mode bit 1 forces timer output when PWM select is 1
// - B pins: nonzero mode forces timer output
// - Channel-1 A pin: code alone under PWM select
// - Channel-0 B pin mostly timer output
// - Channel-0 A pin: sync bit frees pin
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "gps_cfg.svh"
module gps_ports
   import gps_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [`GPS_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] p8_pin_in,
   output logic [2:0] p8_pin_out,
   output logic [2:0] p8_pin_oe,
   input wire logic [3:0] pc_pin_in,
   output logic [3:0] pc_pin_out,
   output logic [3:0] pc_pin_oe,
   input wire logic [7:0] pd_pin_in,
   output logic [7:0] pd_pin_out,
   output logic [7:0] pd_pin_oe,
   input wire logic [7:0] timer_out,
   output logic [7:0] timer_capture_in
);
   // ==========================================
   // Register storage
   logic [2:0] first_port_direction;
   logic [2:0] first_port_latch;
   logic [3:0] second_port_direction;
   logic [3:0] second_port_latch;
   gps_byte_t shared_port_direction;
   gps_byte_t shared_port_latch;
   gps_byte_t timer_output_disable_reg;
   gps_byte_t timer_function_ctrl_reg;
   gps_byte_t timer_pwm_mode_reg;
   gps_byte_t timer_io_ctrl_a_reg;
   gps_byte_t timer_io_ctrl_c_reg;
   gps_byte_t timer_io_ctrl_a1_reg;
   gps_byte_t timer_io_ctrl_c1_reg;

   // ==========================================
   // Pin input synchronisers
   logic [2:0] p8_meta;
   logic [2:0] p8_sync;
   logic [3:0] pc_meta;
   logic [3:0] pc_sync;
   gps_byte_t pd_meta;
   gps_byte_t pd_sync;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         p8_meta <= `GPS_RST_P8;
         p8_sync <= `GPS_RST_P8;
         pc_meta <= `GPS_RST_PC;
         pc_sync <= `GPS_RST_PC;
         pd_meta <= `GPS_RST_BYTE;
         pd_sync <= `GPS_RST_BYTE;
      end else begin
         p8_meta <= p8_pin_in;
         p8_sync <= p8_meta;
         pc_meta <= pc_pin_in;
         pc_sync <= pc_meta;
         pd_meta <= pd_pin_in;
         pd_sync <= pd_meta;
      end
   end

   // ==========================================
   // Write decode
   logic wr_p8_dir;
   logic wr_p8_data;
   logic wr_pc_dir;
   logic wr_pc_data;
   logic wr_pd_dir;
   logic wr_pd_data;

   assign wr_p8_dir = reg_wr && (reg_addr == `GPS_OFS_P8_DIR);
   assign wr_p8_data = reg_wr && (reg_addr == `GPS_OFS_P8_DATA);
   assign wr_pc_dir = reg_wr && (reg_addr == `GPS_OFS_PC_DIR);
   assign wr_pc_data = reg_wr && (reg_addr == `GPS_OFS_PC_DATA);
   assign wr_pd_dir = reg_wr && (reg_addr == `GPS_OFS_PD_DIR);
   assign wr_pd_data = reg_wr && (reg_addr == `GPS_OFS_PD_DATA);

   // ==========================================
   // First port
   // Only the three upper bits exist; low-bit writes fall away
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         first_port_direction <= `GPS_RST_P8;
      end else if (wr_p8_dir) begin
         first_port_direction <= reg_wdata[7:`GPS_P8_LSB];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         first_port_latch <= `GPS_RST_P8;
      end else if (wr_p8_data) begin
         first_port_latch <= reg_wdata[7:`GPS_P8_LSB];
      end
   end

   // ==========================================
   // Second port
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         second_port_direction <= `GPS_RST_PC;
      end else if (wr_pc_dir) begin
         second_port_direction <= reg_wdata[3:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         second_port_latch <= `GPS_RST_PC;
      end else if (wr_pc_data) begin
         second_port_latch <= reg_wdata[3:0];
      end
   end

   // ==========================================
   // Shared port
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shared_port_direction <= `GPS_RST_BYTE;
      end else if (wr_pd_dir) begin
         shared_port_direction <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shared_port_latch <= `GPS_RST_BYTE;
      end else if (wr_pd_data) begin
         shared_port_latch <= reg_wdata;
      end
   end

   // ==========================================
   // Timer pin-function configuration
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_output_disable_reg <= `GPS_RST_BYTE;
         timer_function_ctrl_reg <= `GPS_RST_BYTE;
         timer_pwm_mode_reg <= `GPS_RST_BYTE;
         timer_io_ctrl_a_reg <= `GPS_RST_BYTE;
         timer_io_ctrl_c_reg <= `GPS_RST_BYTE;
         timer_io_ctrl_a1_reg <= `GPS_RST_BYTE;
         timer_io_ctrl_c1_reg <= `GPS_RST_BYTE;
      end else if (reg_wr) begin
         case (reg_addr)
            `GPS_OFS_TMR_ODIS: timer_output_disable_reg <= reg_wdata;
            `GPS_OFS_TMR_FUNC: timer_function_ctrl_reg <= reg_wdata;
            // A pins carry no PWM-mode bit, so those positions never store
            `GPS_OFS_TMR_PWM: timer_pwm_mode_reg <= reg_wdata & `GPS_PWM_IMPL;
            `GPS_OFS_TMR_IOA0: timer_io_ctrl_a_reg <= reg_wdata;
            `GPS_OFS_TMR_IOC0: timer_io_ctrl_c_reg <= reg_wdata;
            `GPS_OFS_TMR_IOA1: timer_io_ctrl_a1_reg <= reg_wdata;
            `GPS_OFS_TMR_IOC1: timer_io_ctrl_c1_reg <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // Per-pin timer ownership of the shared port
   logic [1:0] comb_mode;
   logic pwm_sel;
   logic start_sync;
   logic [3:0] io_code [8];
   gps_byte_t tmr_owns;
   gps_byte_t tmr_force_in;

   assign comb_mode = timer_function_ctrl_reg[`GPS_FUNC_CMD_LSB +: 2];
   assign pwm_sel = timer_function_ctrl_reg[`GPS_FUNC_PWM_SEL_BIT];
   assign start_sync = timer_function_ctrl_reg[`GPS_FUNC_SYNC_BIT];
   assign io_code[0] = {1'b0, timer_io_ctrl_a_reg[2:0]};
   assign io_code[1] = {1'b0, timer_io_ctrl_a_reg[6:4]};
   assign io_code[2] = timer_io_ctrl_c_reg[3:0];
   assign io_code[3] = timer_io_ctrl_c_reg[7:4];
   assign io_code[4] = {1'b0, timer_io_ctrl_a1_reg[2:0]};
   assign io_code[5] = {1'b0, timer_io_ctrl_a1_reg[6:4]};
   assign io_code[6] = timer_io_ctrl_c1_reg[3:0];
   assign io_code[7] = timer_io_ctrl_c1_reg[7:4];

   localparam gps_pin_kind_t PIN_KIND [8] = '{
      GPS_PIN_A0, GPS_PIN_B0, GPS_PIN_CD, GPS_PIN_CD,
      GPS_PIN_A1, GPS_PIN_B1, GPS_PIN_CD, GPS_PIN_CD
   };

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_mux
         gps_pinmux #(
            .KIND(PIN_KIND[gi])
         ) u_mux (
            .out_disable(timer_output_disable_reg[gi]),
            .comb_mode(comb_mode),
            .pwm_sel(pwm_sel),
            .start_sync(start_sync),
            .pwm_mode(timer_pwm_mode_reg[gi]),
            .io_code(io_code[gi]),
            .timer_owns(tmr_owns[gi]),
            .force_input(tmr_force_in[gi])
         );
      end
   endgenerate

   // ==========================================
   // Pin drivers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         p8_pin_out <= `GPS_RST_P8;
         p8_pin_oe <= `GPS_RST_P8;
      end else begin
         p8_pin_out <= first_port_latch;
         p8_pin_oe <= first_port_direction;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_pin_out <= `GPS_RST_PC;
         pc_pin_oe <= `GPS_RST_PC;
      end else begin
         pc_pin_out <= second_port_latch;
         pc_pin_oe <= second_port_direction;
      end
   end

   // Timer ownership wins over direction and latch
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pd_pin_out <= `GPS_RST_BYTE;
         pd_pin_oe <= `GPS_RST_BYTE;
      end else begin
         pd_pin_out <= (tmr_owns & timer_out) | (~tmr_owns & shared_port_latch);
         pd_pin_oe <= tmr_owns | (~tmr_force_in & shared_port_direction);
      end
   end

   // Capture always sees the pin; the timer only uses it when the pin is an input
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_capture_in <= `GPS_RST_BYTE;
      end else begin
         timer_capture_in <= pd_sync;
      end
   end

   // ==========================================
   // Read path
   gps_byte_t next_rdata;
   logic [2:0] p8_view;
   logic [3:0] pc_view;
   gps_byte_t pd_view;

   assign p8_view = (first_port_direction & first_port_latch) | (~first_port_direction & p8_sync);
   assign pc_view = (second_port_direction & second_port_latch) | (~second_port_direction & pc_sync);
   assign pd_view = (shared_port_direction & shared_port_latch) | (~shared_port_direction & pd_sync);

   // Direction registers are write-only and read back as zero
   always_comb begin
      case (reg_addr)
         `GPS_OFS_P8_DATA: next_rdata = {p8_view, `GPS_P8_RSVD_RD};
         `GPS_OFS_PC_DATA: next_rdata = {`GPS_PC_RSVD_RD, pc_view};
         `GPS_OFS_PD_DATA: next_rdata = pd_view;
         `GPS_OFS_TMR_ODIS: next_rdata = timer_output_disable_reg;
         `GPS_OFS_TMR_FUNC: next_rdata = timer_function_ctrl_reg;
         `GPS_OFS_TMR_PWM: next_rdata = timer_pwm_mode_reg;
         `GPS_OFS_TMR_IOA0: next_rdata = timer_io_ctrl_a_reg;
         `GPS_OFS_TMR_IOC0: next_rdata = timer_io_ctrl_c_reg;
         `GPS_OFS_TMR_IOA1: next_rdata = timer_io_ctrl_a1_reg;
         `GPS_OFS_TMR_IOC1: next_rdata = timer_io_ctrl_c1_reg;
         default: next_rdata = `GPS_RD_UNMAPPED;
      endcase
   end

   // Read data stands one cycle only, zero otherwise
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= `GPS_RST_BYTE;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= `GPS_RST_BYTE;
      end
   end
endmodule
`default_nettype wire

// ===== gps_ports_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gps_ports_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [2:0] p8_pin_out,
   input wire logic [2:0] p8_pin_oe,
   input wire logic [3:0] pc_pin_out,
   input wire logic [3:0] pc_pin_oe,
   input wire logic [7:0] pd_pin_in,
   input wire logic [7:0] timer_capture_in
);
   // ==========
   // Port checks
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [2:0] up;
   logic [4:0] rq;
   logic [4:0] wq;
   assign rq = {reg_rd, reg_addr};
   assign wq = {reg_wr, reg_addr};
   // Capture lags three stages, so wait until they hold post-reset levels
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         up <= 3'h0;
      end else if (up != 3'h7) begin
         up <= up + 3'h1;
      end
   end
   chk_rd_idle: assert property (!$past(rq[4]) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   chk_p8_rsvd: assert property ($past(rq) == 5'h11 |-> reg_rdata[4:0] == 5'h1F)
      else $error("first port reserved bits");
   chk_pc_rsvd: assert property ($past(rq) == 5'h13 |-> reg_rdata[7:4] == 4'hF)
      else $error("second port reserved bits");
   chk_dir_wo: assert property ($past(rq) inside {5'h10, 5'h12, 5'h14} |-> reg_rdata == 8'h00)
      else $error("direction readback");
   chk_unmapped_rd: assert property ($past(rq) > 5'h1C |-> reg_rdata == 8'h00)
      else $error("unmapped readback");
   chk_p8_dir_oe: assert property (wq == 5'h10 ##1 wq != 5'h10 |=> p8_pin_oe == $past(reg_wdata[7:5], 2))
      else $error("first port enable");
   chk_pc_dir_oe: assert property (wq == 5'h12 ##1 wq != 5'h12 |=> pc_pin_oe == $past(reg_wdata[3:0], 2))
      else $error("second port enable");
   chk_p8_drive: assert property (wq == 5'h11 ##1 wq != 5'h11 |=>
      (p8_pin_out & p8_pin_oe) == ($past(reg_wdata[7:5], 2) & p8_pin_oe)) else $error("first port drive");
   chk_pc_drive: assert property (wq == 5'h13 ##1 wq != 5'h13 |=>
      (pc_pin_out & pc_pin_oe) == ($past(reg_wdata[3:0], 2) & pc_pin_oe)) else $error("second port drive");
   chk_cap_pin: assert property (up == 3'h7 |-> timer_capture_in == $past(pd_pin_in, 3))
      else $error("capture level");
   cover property (wq == 5'h14);
   cover property ($past(rq) == 5'h15);
   cover property (wq == 5'h17 && reg_wdata[1:0] != 2'h0);
endmodule
bind gps_ports gps_ports_chk gps_ports_chk_i (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .p8_pin_out, .p8_pin_oe, .pc_pin_out, .pc_pin_oe, .pd_pin_in, .timer_capture_in);
`default_nettype wire

// ===== gps_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module gps_pin_model #(
   parameter int W = 8
) (
   input wire logic [W-1:0] drv,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] ext,
   output logic [W-1:0] pin
);
   // ==========
   // Pads
   // A released pad shows the outside level, which the bench keeps changing
   assign pin = (oe & drv) | (~oe & ext);
endmodule
`default_nettype wire

// ===== gps_ports_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "gps_cfg.svh"
module gps_ports_test
   import gps_pkg::*;
;
   // ==========
   // Bench
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   gps_byte_t reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   gps_byte_t reg_rdata, pd_in, pd_out, pd_oe, cap, e, pv;
   gps_byte_t tmr = 8'h00;
   gps_byte_t pd_ext = 8'h00;
   logic [2:0] p8_in, p8_out, p8_oe;
   logic [2:0] p8_ext = 3'h0, p8d = 3'h0, p8l = 3'h0;
   logic [3:0] pc_in, pc_out, pc_oe;
   logic [3:0] pc_ext = 4'h0, pcd = 4'h0, pcl = 4'h0;
   gps_byte_t od = 8'h00, fn = 8'h00, pm = 8'h00, a0 = 8'h00, c0 = 8'h00;
   gps_byte_t a1 = 8'h00, c1 = 8'h00, pdd = 8'h00, pdl = 8'h00;
   logic [15:0] m;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   always #12.5 clk = ~clk;
   gps_ports gps_ports_i (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .p8_pin_in(p8_in), .p8_pin_out(p8_out), .p8_pin_oe(p8_oe), .pc_pin_in(pc_in), .pc_pin_out(pc_out),
      .pc_pin_oe(pc_oe), .pd_pin_in(pd_in), .pd_pin_out(pd_out), .pd_pin_oe(pd_oe), .timer_out(tmr),
      .timer_capture_in(cap));
   gps_pin_model #(.W(3)) p8_pads (.drv(p8_out), .oe(p8_oe), .ext(p8_ext), .pin(p8_in));
   gps_pin_model #(.W(4)) pc_pads (.drv(pc_out), .oe(pc_oe), .ext(pc_ext), .pin(pc_in));
   gps_pin_model #(.W(8)) pd_pads (.drv(pd_out), .oe(pd_oe), .ext(pd_ext), .pin(pd_in));
   task automatic chk(input gps_byte_t seen, input gps_byte_t exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input gps_byte_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input gps_byte_t exp, input string what);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp, what);
   endtask
   function automatic logic ab(input logic [2:0] c);
      return c inside {3'h1, 3'h2, 3'h3};
   endfunction
   function automatic logic cd(input logic [3:0] c);
      return c inside {4'h9, 4'hA, 4'hB};
   endfunction
   // Upper half: pins forced to input; lower half: pins owned by the timer
   function automatic logic [15:0] own();
      logic [7:0] o;
      logic [7:0] fi;
      o = {fn[2] && (pm[7] || cd(c1[7:4])), fn[2] && (pm[6] || cd(c1[3:0])),
         fn[2] && (pm[5] || ab(a1[6:4])), fn[2] && ab(a1[2:0]),
         fn[2] && (pm[3] || cd(c0[7:4])), fn[2] && (pm[2] || cd(c0[3:0])),
         !fn[2] || pm[1] || ab(a0[6:4]), !fn[2] || ab(a0[2:0])};
      fi = 8'h00;
      if (fn[1:0] != 2'h0) begin
         o = 8'hFE;
         fi = 8'h01;
      end
      if (fn[3]) begin
         o[0] = 1'b0;
         fi[0] = 1'b0;
      end
      return {fi & ~od, o & ~od};
   endfunction
   task automatic shake();
      @(posedge clk);
      p8_ext <= 3'($urandom);
      pc_ext <= 4'($urandom);
      pd_ext <= 8'($urandom);
      tmr <= 8'($urandom);
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic look();
      m = own();
      e = pdd & ~m[15:8] & ~m[7:0];
      pv = (m[7:0] & tmr) | (e & pdl) | (~m[7:0] & ~e & pd_ext);
      chk({5'h0, p8_oe}, {5'h0, p8d}, "p8 enable");
      chk({5'h0, p8_out & p8d}, {5'h0, p8l & p8d}, "p8 drive");
      chk({4'h0, pc_oe}, {4'h0, pcd}, "pc enable");
      chk({4'h0, pc_out & pcd}, {4'h0, pcl & pcd}, "pc drive");
      chk(pd_oe, m[7:0] | e, "pd enable");
      chk(pd_out & (m[7:0] | e), (tmr & m[7:0]) | (pdl & e), "pd drive");
      chk(cap, pv, "capture");
      rd(`GPS_OFS_P8_DATA, {(p8d & p8l) | (~p8d & p8_ext), 5'h1F}, "p8 read");
      rd(`GPS_OFS_PC_DATA, {4'hF, (pcd & pcl) | (~pcd & pc_ext)}, "pc read");
      rd(`GPS_OFS_PD_DATA, (pdd & pdl) | (~pdd & pv), "pd read");
   endtask
   // Offsets run 0 to 12 in register order; reserved direction bits get noise
   task automatic step();
      gps_byte_t v[13];
      {p8d, p8l, pcd, pcl} = 14'($urandom);
      {pdd, pdl} = 16'($urandom);
      v = '{{p8d, 5'($urandom)}, {p8l, 5'h00}, {4'($urandom), pcd}, {4'h0, pcl},
         pdd, pdl, od, fn, pm, a0, c0, a1, c1};
      for (int i = 0; i < 13; i++) begin
         wr(4'(i), v[i]);
      end
      wr(4'hD, 8'hFF);
      shake();
      look();
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(26));
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      shake();
      look();
      $display("reset test done");
      od = 8'hFF;
      repeat (12) step();
      $display("gpio test done");
      od = 8'h00;
      fn = 8'h04;
      for (int k = 0; k < 16; k++) begin
         a0 = {4'(k), 4'(k)};
         c0 = a0;
         a1 = a0;
         c1 = a0;
         step();
      end
      $display("code sweep done");
      // Each mode, PWM select and sync setting three times, other timer fields random
      for (int f = 0; f < 48; f++) begin
         {od, pm, a0, c0} = $urandom;
         {a1, c1} = 16'($urandom);
         fn = {4'h0, 4'(f)};
         step();
      end
      $display("timer mux test done");
      for (int a = 0; a < 16; a++) begin
         if (a inside {0, 2, 4, 13, 14, 15}) begin
            rd(4'(a), 8'h00, "no readback");
         end
      end
      $display("readback test done");
      wrap_up();
   end
endmodule
`default_nettype wire
